/* File: shs_consts.svh */
// Purpose : constants for the homing and status discrete i/o block
// Assumes : apb byte addresses, 32-bit data, one aligned word per register
// Notes   : register offsets and field values live here, types live in shs_pkg
`ifndef SHS_CONSTS_SVH
`define SHS_CONSTS_SVH
// ==========================================================
// register map
`define SHS_OFS_CTRL      8'h00
`define SHS_OFS_IN_A      8'h04
`define SHS_OFS_IN_B      8'h08
`define SHS_OFS_OUT_ALLOC 8'h0C
`define SHS_OFS_THRESH    8'h10
`define SHS_OFS_STATUS    8'h14
`define SHS_OFS_INT_STAT  8'h18
`define SHS_OFS_INT_MASK  8'h1C
// ==========================================================
// fields and values
`define SHS_ROUTE_HOME    4'h8
`define SHS_THRESH_RST    12'h014
`define SHS_THRESH_MAX    12'hBB8
`define SHS_MODE_MAX      4'hA
`define SHS_NUM_TERM      8
`define SHS_NUM_PAIR      3
`define SHS_NUM_INT       3
`define SHS_INT_DONE      0
`define SHS_INT_FAULT     1
`define SHS_INT_CLEAR     2
`endif

/* File: shs_pkg.sv */
// Purpose : types for the homing and status discrete i/o block
// Assumes : nothing
// Notes   : gray codes along idle-search-creep-done
package shs_pkg;
   typedef enum logic [1:0] {
      SHS_IDLE   = 2'h0,
      SHS_SEARCH = 2'h1,
      SHS_CREEP  = 2'h3,
      SHS_DONE   = 2'h2
   } shs_state_t;
endpackage

/* File: shs_sync.sv */
// Purpose : two flip-flop synchroniser for pin inputs
// Assumes : inputs asynchronous to SYS_CLK
// Notes   : first stage is read by the second stage only
`timescale 1ns/10ps
module shs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

/* File: shs_edge.sv */
// Purpose : rising edge detector
// Assumes : inputs already synchronous
// Notes   : rise is combinational, one cycle wide
`timescale 1ns/10ps
module shs_edge #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] rise
);
   logic [W-1:0] prev_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= d;
      end
   end
   assign rise = d & ~prev_q;
endmodule

/* File: shs_top.sv */
// Purpose : homing inputs, homing complete routing, fault, rotation, ready
// Assumes : MOTOR_SPEED and FAULT_* come from logic on SYS_CLK
// Notes   : apb slave with zero wait states, error on unmapped offsets
//
// Added by the designer: register access over APB and the register addresses.
`include "shs_consts.svh"
`timescale 1ns/10ps
module shs_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [7:0]  IN_TERM,
   input  wire logic        ENC_INDEX,
   input  wire logic        LIMIT_FWD,
   input  wire logic        LIMIT_REV,
   input  wire logic        FAULT_CLEAR_IN,
   input  wire logic        PANEL_KEY,
   input  wire logic        MAIN_POWER,
   input  wire logic        SERVO_ON,
   input  wire logic        FAULT_REQ,
   input  wire logic        FAULT_HARD,
   input  wire logic [11:0] MOTOR_SPEED,
   output logic      [2:0]  HOME_DONE_N,
   output logic             HOME_RUN_OUT,
   output logic             HOME_DIR_OUT,
   output logic             HOME_SLOW_OUT,
   output logic             FAULT_INDICATOR_OUT,
   output logic             ROTATION_DETECT_OUT,
   output logic             SERVO_READY_OUT,
   output logic             SERVO_ENABLE_OUT,
   output logic             IRQ
);
   import shs_pkg::*;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   // ==========================================================
   // pin synchronisers and edges
   logic [14:0] pins_s;
   logic [7:0]  term_s;
   logic        idx_s, limf_s, limr_s, clr_s, key_s, pwr_s, son_s;
   logic        homing_start_in, origin_switch_in;
   logic [7:0]  rise;
   logic        start_rise, org_rise, idx_rise, limf_rise, limr_rise;
   logic        clr_rise, key_rise, pwr_rise;

   shs_sync #(.W(15)) u_sync (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .d     ({SERVO_ON, MAIN_POWER, PANEL_KEY, FAULT_CLEAR_IN,
               LIMIT_REV, LIMIT_FWD, ENC_INDEX, IN_TERM}),
      .q     (pins_s)
   );
   assign {son_s, pwr_s, key_s, clr_s, limr_s, limf_s, idx_s, term_s} =
      pins_s;

   function automatic logic pick_term(input logic [7:0] t,
                                      input logic [2:0] sel);
      pick_term = t[sel];
   endfunction

   logic [2:0] in_a_q, in_b_q;
   // terminal choice is software's job before homing is asked for
   assign homing_start_in  = pick_term(term_s, in_a_q);
   assign origin_switch_in = pick_term(term_s, in_b_q);

   shs_edge #(.W(8)) u_edge (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .d     ({pwr_s, key_s, clr_s, limr_s, limf_s, idx_s,
               origin_switch_in, homing_start_in}),
      .rise  (rise)
   );
   assign {pwr_rise, key_rise, clr_rise, limr_rise, limf_rise, idx_rise,
           org_rise, start_rise} = rise;

   // ==========================================================
   // apb slave
   logic [3:0]  ctrl_q;
   logic [11:0] out_alloc_q;
   logic [11:0] thresh_q;
   logic [2:0]  int_stat_q, int_mask_q, ev;
   logic [31:0] status;
   logic        setup, wr_acc;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `SHS_OFS_INT_MASK);
   endfunction

   assign setup  = PSEL & ~PENABLE;
   assign wr_acc = PSEL & PENABLE & PREADY & PWRITE & mapped(PADDR);

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY <= 1'b1;
         if (setup) begin
            PSLVERR <= ~mapped(PADDR);
            PRDATA  <= 32'h0000_0000;
            if (!PWRITE) begin
               unique case (PADDR)
                  `SHS_OFS_CTRL:      PRDATA <= {28'h0, ctrl_q};
                  `SHS_OFS_IN_A:      PRDATA <= {29'h0, in_a_q};
                  `SHS_OFS_IN_B:      PRDATA <= {29'h0, in_b_q};
                  `SHS_OFS_OUT_ALLOC: PRDATA <= {20'h0, out_alloc_q};
                  `SHS_OFS_THRESH:    PRDATA <= {20'h0, thresh_q};
                  `SHS_OFS_STATUS:    PRDATA <= status;
                  `SHS_OFS_INT_STAT:  PRDATA <= {29'h0, int_stat_q};
                  `SHS_OFS_INT_MASK:  PRDATA <= {29'h0, int_mask_q};
                  default:            PRDATA <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q      <= 4'h0;
         in_a_q      <= 3'h0;
         in_b_q      <= 3'h1;
         out_alloc_q <= 12'h000;
         int_mask_q  <= 3'h0;
      end else if (wr_acc) begin
         unique case (PADDR)
            `SHS_OFS_CTRL:      ctrl_q      <= PWDATA[3:0];
            `SHS_OFS_IN_A:      in_a_q      <= PWDATA[2:0];
            `SHS_OFS_IN_B:      in_b_q      <= PWDATA[2:0];
            `SHS_OFS_OUT_ALLOC: out_alloc_q <= PWDATA[11:0];
            `SHS_OFS_INT_MASK:  int_mask_q  <= PWDATA[2:0];
            default:            ;
         endcase
      end
   end

   // thresholds above the maximum in PWDATA[15:0] clamp; PWDATA bits 31:16 are ignored
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         thresh_q <= `SHS_THRESH_RST;
      end else if (wr_acc && PADDR == `SHS_OFS_THRESH) begin
         if (PWDATA[15:0] > {4'h0, `SHS_THRESH_MAX}) begin
            thresh_q <= `SHS_THRESH_MAX;
         end else begin
            thresh_q <= PWDATA[11:0];
         end
      end
   end

   // ==========================================================
   // interrupts: set wins over a write-one clear
   logic [2:0] w1c;
   assign w1c = (wr_acc && PADDR == `SHS_OFS_INT_STAT) ?
                PWDATA[2:0] : 3'h0;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         int_stat_q <= 3'h0;
         IRQ        <= 1'b0;
      end else begin
         int_stat_q <= (int_stat_q & ~w1c) | ev;
         IRQ        <= |(int_stat_q & int_mask_q);
      end
   end

   // ==========================================================
   // fault status
   logic fault_active_q, fault_hard_q, clr_ok;

   // hard class waits for a power cycle, which is RST_N here
   assign clr_ok = (clr_rise | key_rise) & ~fault_hard_q & ~FAULT_REQ;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fault_active_q <= 1'b0;
         fault_hard_q   <= 1'b0;
      end else begin
         if (FAULT_REQ) begin
            fault_active_q <= 1'b1;
         end else if (clr_ok) begin
            fault_active_q <= 1'b0;
         end
         if (FAULT_REQ && FAULT_HARD) begin
            fault_hard_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // homing sequencer
   shs_state_t state_q, state_d;
   logic [3:0] mode_act_q;
   logic       dir_q, dir_d, fwd_mode, start_ok, travel_lim;
   logic       decel_ev, same_origin, home_done_q;

   // a new method only lands when main power comes back
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_act_q <= 4'h0;
      end else if (pwr_rise) begin
         mode_act_q <= ctrl_q;
      end
   end

   assign fwd_mode   = mode_act_q[0];
   assign travel_lim = dir_q ? limf_rise : limr_rise;
   assign start_ok   = start_rise & ~fault_active_q;

   always_comb begin
      decel_ev    = 1'b0;
      same_origin = 1'b0;
      unique case (mode_act_q)
         4'h1, 4'h2: begin
            decel_ev    = org_rise;
            same_origin = 1'b1;
         end
         4'h3, 4'h4: decel_ev = org_rise;
         4'h5, 4'h6: begin
            decel_ev    = idx_rise;
            same_origin = 1'b1;
         end
         4'h7, 4'h8: begin
            decel_ev    = travel_lim;
            same_origin = 1'b1;
         end
         4'h9, 4'hA: decel_ev = travel_lim;
         default:    ;
      endcase
   end

   always_comb begin
      state_d = state_q;
      dir_d   = dir_q;
      unique case (state_q)
         SHS_IDLE, SHS_DONE: begin
            if (start_ok) begin
               if (mode_act_q == 4'h0 || mode_act_q > `SHS_MODE_MAX) begin
                  state_d = SHS_DONE;
               end else begin
                  state_d = SHS_SEARCH;
                  dir_d   = fwd_mode;
               end
            end
         end
         SHS_SEARCH: begin
            if (decel_ev) begin
               state_d = same_origin ? SHS_DONE : SHS_CREEP;
            end else if (travel_lim && mode_act_q <= 4'h6) begin
               dir_d = ~dir_q;
            end
         end
         SHS_CREEP: begin
            if (idx_rise) begin
               state_d = SHS_DONE;
            end
         end
      endcase
      if (fault_active_q) begin
         state_d = SHS_IDLE;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= SHS_IDLE;
         dir_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         dir_q   <= dir_d;
      end
   end

   assign ev[`SHS_INT_DONE]  = (state_d == SHS_DONE) &&
                               (state_q != SHS_DONE);
   assign ev[`SHS_INT_FAULT] = FAULT_REQ & ~fault_active_q;
   assign ev[`SHS_INT_CLEAR] = clr_ok & fault_active_q;

   // ==========================================================
   // status register and pin outputs
   assign status = {15'h0, home_done_q, mode_act_q, 2'h0, state_q,
                    2'h0, SERVO_READY_OUT, ROTATION_DETECT_OUT,
                    pwr_s, origin_switch_in, fault_hard_q,
                    fault_active_q};

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         home_done_q   <= 1'b0;
         HOME_RUN_OUT  <= 1'b0;
         HOME_DIR_OUT  <= 1'b0;
         HOME_SLOW_OUT <= 1'b0;
      end else begin
         home_done_q   <= (state_q == SHS_DONE);
         HOME_RUN_OUT  <= (state_q == SHS_SEARCH) ||
                          (state_q == SHS_CREEP);
         HOME_DIR_OUT  <= dir_q;
         HOME_SLOW_OUT <= (state_q == SHS_CREEP);
      end
   end

   // unrouted pairs idle high, i.e. off
   for (genvar p = 0; p < `SHS_NUM_PAIR; p++) begin : g_pair
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
         if (!RST_N) begin
            HOME_DONE_N[p] <= 1'b1;
         end else begin
            HOME_DONE_N[p] <= ~(home_done_q &&
               out_alloc_q[4*p +: 4] == `SHS_ROUTE_HOME);
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         FAULT_INDICATOR_OUT <= 1'b0;
         ROTATION_DETECT_OUT <= 1'b0;
         SERVO_READY_OUT     <= 1'b0;
         SERVO_ENABLE_OUT    <= 1'b0;
      end else begin
         FAULT_INDICATOR_OUT <= ~fault_active_q;
         ROTATION_DETECT_OUT <= MOTOR_SPEED > thresh_q;
         SERVO_READY_OUT     <= pwr_s & ~fault_active_q;
         SERVO_ENABLE_OUT    <= son_s & pwr_s & ~fault_active_q;
      end
   end

   // ==========================================================
   // checks
   a_start_edge_go: assert property (
      (state_q == SHS_IDLE) && start_ok |=> state_q != SHS_IDLE)
      else $error("homing start edge not taken");
   a_no_level_go: assert property (
      (state_q == SHS_IDLE) && !start_rise |=> state_q == SHS_IDLE)
      else $error("homing left idle without an edge");
   a_home_pair_low: assert property (
      HOME_DONE_N[0] == !($past(home_done_q) &&
                          $past(out_alloc_q[3:0]) == 4'h8))
      else $error("homing complete pair 0 wrong");
   a_mode12_done: assert property (
      (state_q == SHS_SEARCH) && (mode_act_q == 4'h1 ||
       mode_act_q == 4'h2) && org_rise && !fault_active_q
      |=> state_q == SHS_DONE ##1 home_done_q)
      else $error("modes 1 2 origin rise missed");
   a_mode34_creep: assert property (
      (state_q == SHS_SEARCH) && (mode_act_q == 4'h3 ||
       mode_act_q == 4'h4) && org_rise && !fault_active_q
      |=> state_q == SHS_CREEP ##1 HOME_SLOW_OUT)
      else $error("modes 3 4 did not creep");
   a_mode56_idx: assert property (
      (state_q == SHS_SEARCH) && (mode_act_q == 4'h5 ||
       mode_act_q == 4'h6) && idx_rise && !fault_active_q
      |=> state_q == SHS_DONE)
      else $error("modes 5 6 index missed");
   a_limit_reverse: assert property (
      (state_q == SHS_SEARCH) && !decel_ev && travel_lim &&
      mode_act_q <= 4'h6 && !fault_active_q
      |=> dir_q != $past(dir_q) && state_q == SHS_SEARCH)
      else $error("limit did not reverse search");
   a_fault_off: assert property (
      FAULT_REQ |=> fault_active_q ##1 !FAULT_INDICATOR_OUT)
      else $error("fault indicator stayed on");
   a_fault_clear: assert property (
      clr_ok |=> !fault_active_q ##1 FAULT_INDICATOR_OUT)
      else $error("fault clear did not restore");
   a_hard_holds: assert property (
      fault_hard_q |=> fault_hard_q && fault_active_q)
      else $error("hard fault cleared");
   // first edge after a reset release still shows the reset value
   a_rotation_thr: assert property (
      $past(RST_N) |->
      ROTATION_DETECT_OUT == ($past(MOTOR_SPEED) > $past(thresh_q)))
      else $error("rotation detect wrong");
   a_ready_cond: assert property (
      SERVO_READY_OUT |-> $past(pwr_s) && !$past(fault_active_q))
      else $error("ready without power or with fault");
   a_servo_on_gate: assert property (
      SERVO_ENABLE_OUT |-> SERVO_READY_OUT)
      else $error("servo on honoured while not ready");
   a_mode_hold: assert property (
      !pwr_rise |=> $stable(mode_act_q))
      else $error("homing method changed without power");
endmodule

/* File: shs_plc.sv */
// Purpose : controller-side model driving the opto-isolated inputs
// Assumes : released inputs sit low, as an open opto does
// Notes   : pins 0-7 terms, 8 index, 9/10 limits, 11 clear, 12 key,
//           13 main power, 14 servo on
`timescale 1ns/10ps
module shs_plc (
   input  wire logic       clk,
   output logic      [7:0] in_term,
   output logic            enc_index,
   output logic            limit_fwd,
   output logic            limit_rev,
   output logic            fault_clear,
   output logic            panel_key,
   output logic            main_power,
   output logic            servo_on
);
   logic [14:0] pins_q = '0;
   assign {servo_on, main_power, panel_key, fault_clear, limit_rev,
           limit_fwd, enc_index, in_term} = pins_q;
   // ==========================================================
   // pin tasks
   task automatic set(input int pin, input logic v);
      @(posedge clk);
      pins_q[pin] <= v;
   endtask
   // pulse long enough to pass the synchroniser; clear only after cause
   task automatic pulse(input int pin);
      set(pin, 1'b1);
      repeat (3) @(posedge clk);
      pins_q[pin] <= 1'b0;
   endtask
endmodule

/* File: servo_homing_status_io_tb.sv */
// Purpose : self-checking bench for the homing and status block
// Assumes : zero wait apb slave, plc model on the pins
// Notes   : fixed waits cover sync plus edge detect latency
`include "shs_consts.svh"
`timescale 1ns/10ps
module servo_homing_status_io_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, thr, sp;
   logic        pready, pslverr, err, f_req = 1'b0, f_hard = 1'b0;
   logic [7:0]  in_term;
   logic        idx, lim_f, lim_r, clr, key, pwr, son;
   logic        run, dir, slow, ind, rot, rdy, ena, irq;
   logic [11:0] speed = 12'h000;
   logic [2:0]  done_n, exp_n;
   logic [31:0] seed = 32'h897F;
   int          failures = 0;
   int          checks_done = 0;
   int          i, k, e, prev;
   int          md[5] = '{0, 1, 3, 5, 7};
   int          dn[5] = '{0, 1, 2, 2, 3};
   int          ev[3] = '{1, 8, 9};
   always #2.5 clk = ~clk;
   shs_plc i_shs_plc (.clk(clk), .in_term(in_term), .enc_index(idx),
      .limit_fwd(lim_f), .limit_rev(lim_r), .fault_clear(clr),
      .panel_key(key), .main_power(pwr), .servo_on(son));
   shs_top i_shs_top (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .IN_TERM(in_term), .ENC_INDEX(idx), .LIMIT_FWD(lim_f),
      .LIMIT_REV(lim_r), .FAULT_CLEAR_IN(clr), .PANEL_KEY(key),
      .MAIN_POWER(pwr), .SERVO_ON(son), .FAULT_REQ(f_req),
      .FAULT_HARD(f_hard), .MOTOR_SPEED(speed), .HOME_DONE_N(done_n),
      .HOME_RUN_OUT(run), .HOME_DIR_OUT(dir), .HOME_SLOW_OUT(slow),
      .FAULT_INDICATOR_OUT(ind), .ROTATION_DETECT_OUT(rot),
      .SERVO_READY_OUT(rdy), .SERVO_ENABLE_OUT(ena), .IRQ(irq));
   // ==========================================================
   // helpers
   function automatic logic [31:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until pready seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         failures++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic fault(input logic hard);
      f_req <= 1'b1;
      f_hard <= hard;
      cyc(1);
      f_req <= 1'b0;
      f_hard <= 1'b0;
      cyc(3);
   endtask
   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      cyc(5);
      rst_n <= 1'b1;
      cyc(2);
      chk(done_n, 3'b111);
      chk(ind, 1'b1);
      apb(1'b0, `SHS_OFS_THRESH, 32'h0);
      chk(rd, 32'h14);
      apb(1'b1, `SHS_OFS_THRESH, 32'hFFF);
      apb(1'b0, `SHS_OFS_THRESH, 32'h0);
      chk(rd, 32'hBB8);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      $display("test registers done");
      for (i = 0; i < 24; i++) begin
         thr = nxt() % 3001;
         apb(1'b1, `SHS_OFS_THRESH, thr);
         sp = (i % 3 == 0) ? thr : (i % 3 == 1) ? thr + 1 : nxt() % 4096;
         speed <= sp[11:0];
         cyc(3);
         chk(rot, sp > thr);
      end
      $display("test rotation done");
      i_shs_plc.set(13, 1'b1);
      i_shs_plc.set(14, 1'b1);
      cyc(6);
      chk(rdy, 1'b1);
      chk(ena, 1'b1);
      apb(1'b1, `SHS_OFS_IN_A, 32'h0);
      apb(1'b1, `SHS_OFS_IN_B, 32'h1);
      prev = 0;
      for (k = 0; k < 5; k++) begin
         exp_n = ~(3'b001 << (k % 3));
         apb(1'b1, `SHS_OFS_OUT_ALLOC, 32'h8 << (4 * (k % 3)));
         apb(1'b1, `SHS_OFS_CTRL, md[k]);
         apb(1'b0, `SHS_OFS_STATUS, 32'h0);
         chk(rd[15:12], prev);
         i_shs_plc.set(13, 1'b0);
         cyc(6);
         i_shs_plc.set(13, 1'b1);
         cyc(6);
         apb(1'b0, `SHS_OFS_STATUS, 32'h0);
         chk(rd[15:12], md[k]);
         prev = md[k];
         if (k == 1) i_shs_plc.set(0, 1'b1);
         else i_shs_plc.pulse(0);
         cyc(8);
         chk(run, dn[k] != 0);
         chk(dir, dn[k] != 0);
         chk(done_n, dn[k] == 0 ? exp_n : 3'b111);
         if (k == 3) begin
            i_shs_plc.pulse(9);
            cyc(8);
            chk(dir, 1'b0);
            chk(run, 1'b1);
         end
         for (e = 0; e < 3; e++) begin
            i_shs_plc.pulse(ev[e]);
            cyc(8);
            chk(done_n, e + 1 >= dn[k] ? exp_n : 3'b111);
            if (k == 2 && e == 0) chk(slow, 1'b1);
         end
         if (k == 1) begin
            i_shs_plc.set(0, 1'b0);
            cyc(8);
            chk(done_n, exp_n);
         end
      end
      i_shs_plc.set(1, 1'b1);
      cyc(6);
      apb(1'b0, `SHS_OFS_STATUS, 32'h0);
      chk(rd[2], 1'b1);
      i_shs_plc.set(1, 1'b0);
      cyc(6);
      apb(1'b0, `SHS_OFS_STATUS, 32'h0);
      chk(rd[2], 1'b0);
      $display("test homing done");
      apb(1'b1, `SHS_OFS_INT_STAT, 32'h7);
      apb(1'b1, `SHS_OFS_INT_MASK, 32'h0);
      fault(1'b0);
      chk(ind, 1'b0);
      chk(rdy, 1'b0);
      chk(ena, 1'b0);
      chk(irq, 1'b0);
      apb(1'b1, `SHS_OFS_INT_MASK, 32'h2);
      cyc(2);
      chk(irq, 1'b1);
      i_shs_plc.pulse(11);
      cyc(8);
      chk(ind, 1'b1);
      chk(rdy, 1'b1);
      apb(1'b1, `SHS_OFS_INT_STAT, 32'h7);
      cyc(2);
      chk(irq, 1'b0);
      fault(1'b0);
      i_shs_plc.pulse(12);
      cyc(8);
      chk(ind, 1'b1);
      fault(1'b1);
      i_shs_plc.pulse(11);
      cyc(8);
      chk(ind, 1'b0);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(3);
      chk(ind, 1'b1);
      $display("test faults done");
      results();
   end
endmodule
